// ### hdl/plrt_pkg.sv
// Purpose: shared constants, register layouts and states of the ride-through sequencer
// Assumes: 50 MHz clock, 1 ms control tick, APB register access
// Notes: times in 0.1 s units, voltages in volts, frequency in 0.01 Hz
`default_nettype none
package plrt_pkg;
   localparam int CLK_NS = 20;
   localparam int TICK_NS = 1_000_000;
   localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
   localparam int DS_TICKS = 100;        // ticks per 0.1 s
   localparam int VDET_MS = 50;          // wait for backup input after bus detection
   localparam int VDET_TICKS = VDET_MS * 1_000_000 / TICK_NS;
   localparam logic [9:0] VMAX = 10'h3e8; // full output voltage, per mille
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_TIME = 8'h04;
   localparam logic [7:0] OFS_RAMP = 8'h08;
   localparam logic [7:0] OFS_DECEL = 8'h0c;
   localparam logic [7:0] OFS_LEVEL = 8'h10;
   localparam logic [7:0] OFS_GAIN = 8'h14;
   localparam logic [7:0] OFS_INV = 8'h18;
   localparam logic [7:0] OFS_REG2 = 8'h1c;
   localparam logic [7:0] OFS_STAT = 8'h20;
   localparam logic [7:0] FN_FIX_NC = 8'h65;
   localparam logic [7:0] FN_FIX_NO = 8'h66;
   localparam logic [7:0] FN_REG_NC = 8'h7a;
   localparam logic [7:0] FN_REG_NO = 8'h7b;
   localparam logic [7:0] RST_UV = 8'hbe;       // 190 V
   localparam logic [8:0] RST_INV = 9'h0c8;     // 200 V
   localparam logic [8:0] RST_TGT = 9'h0f4;     // 200 V x 1.22
   localparam logic [8:0] RST_GAIN = 9'h064;    // 100 %
   localparam logic [7:0] RST_RIDE = 8'h05;
   localparam logic [7:0] RST_MINOFF = 8'h05;
   localparam logic [7:0] RST_VRAMP = 8'h03;
   localparam logic [11:0] RST_FSTOP = 12'h00a;
   localparam logic [11:0] RST_NACC = 12'h064;
   localparam logic [31:0] RST_REG2 = 32'h0a_0a_0a_0a;
   typedef struct packed {
      logic clr_fault; logic [13:0] rsv; logic high_class; logic [7:0] func_sel; logic [5:0] rsv2; logic [1:0] mode;
   } plrt_ctrl_t;
   typedef struct packed {logic [7:0] rsv; logic [7:0] min_off; logic [7:0] rsv2; logic [7:0] ride;} plrt_time_t;
   typedef struct packed {logic [7:0] rsv; logic [7:0] bk_acc; logic [7:0] rsv2; logic [7:0] v_ramp;} plrt_ramp_t;
   typedef struct packed {logic [3:0] rsv; logic [11:0] fast_stop; logic [3:0] rsv2; logic [11:0] bk_dec;} plrt_decel_t;
   typedef struct packed {logic [6:0] rsv; logic [8:0] bus_tgt; logic [7:0] rsv2; logic [7:0] uv_level;} plrt_level_t;
   typedef struct packed {logic [3:0] rsv; logic [11:0] norm_acc; logic [6:0] rsv2; logic [8:0] step_gain;} plrt_gain_t;
   typedef struct packed {logic [7:0] inertia; logic [7:0] accel_ref; logic [7:0] rate_gain; logic [7:0] bus_gain;} plrt_reg2_t;
   typedef enum logic [2:0] {ST_RUN, ST_OFF, ST_SRCH, ST_BK_DEC, ST_BK_ACC, ST_FAULT} plrt_state_t;
   typedef struct packed {
      logic [24:0] rsv; logic fault; logic backup; logic out_en; logic by_volt; plrt_state_t st;
   } plrt_stat_t;
endpackage : plrt_pkg
`default_nettype wire

// ### hdl/plrt_top.sv
// Purpose: momentary power loss sequencing with energy backup, APB configured
// Assumes: all inputs synchronous to i_clk; bus voltage in volts
// Notes: sequencing steps once per control tick; APB answers with no wait state
// Notes on behaviour
// - output off at least minimum off time
// - voltage ramps zero to full in ramp time
// - bus below undervoltage level trips, backs up, or turns output off and restarts
// - higher class doubles voltage thresholds
// - input voltage write restores undervoltage default
// - fixed backup decel, fast stop when zero
// - fixed backup reaccel, normal accel when zero
// - regulating mode holds bus at target
// - regulating mode reaccelerates with normal accel
// - backup needs mode 1/2 and function code
// - bus low or input starts backup
// - no input within 50 ms ends backup
// - input release ends backup
// - no run command means no reacceleration
// - backup decel time spans onset reference to zero
// - backup accel time spans end speed to reference
// - fixed onset step is slip times gain times two
// - bus target default is input voltage x1.22
// - mode 1 trips after ride-through time
`default_nettype none
module plrt_top #(
   parameter int P_TICK_CYC = plrt_pkg::TICK_CYC,
   parameter logic [15:0] P_FMAX = 16'h1770
) (
   input wire logic i_clk,              // 50 MHz clock
   input wire logic i_rst_b,            // async reset, active low
   input wire logic i_psel,             // apb select
   input wire logic i_penable,          // apb enable
   input wire logic i_pwrite,           // apb direction
   input wire logic [7:0] i_paddr,      // apb byte address
   input wire logic [31:0] i_pwdata,    // apb write data
   output logic [31:0] o_prdata,        // apb read data
   output logic o_pready,               // apb ready
   output logic o_pslverr,              // unmapped address
   input wire logic [9:0] i_bus_v,      // dc bus voltage, volts
   input wire logic i_backup_pin,       // backup input terminal
   input wire logic i_run,              // run command
   input wire logic [15:0] i_freq_ref,  // frequency reference
   input wire logic [15:0] i_slip,      // present slip frequency
   output logic o_out_en,               // motor output enabled
   output logic [15:0] o_freq,          // output frequency
   output logic [9:0] o_volt,           // output voltage, per mille
   output logic o_uv_fault,             // undervoltage fault
   output logic o_backup                // energy backup active
);
   if (P_TICK_CYC < 2) $error("P_TICK_CYC too small");
   if (P_FMAX == 16'h0000) $error("P_FMAX must be nonzero");

   plrt_pkg::plrt_ctrl_t ctrl_q;
   plrt_pkg::plrt_time_t time_q;
   plrt_pkg::plrt_ramp_t ramp_q;
   plrt_pkg::plrt_decel_t dec_q;
   plrt_pkg::plrt_level_t lvl_q;
   plrt_pkg::plrt_gain_t gain_q;
   plrt_pkg::plrt_reg2_t reg2_q;
   logic [8:0] inv_q;
   logic clr_q;
   plrt_pkg::plrt_state_t st_q;
   logic [17:0] tmr_q;
   logic [15:0] onset_f_q, astep_q;
   logic by_volt_q, seen_q, tick_q;
   logic [31:0] cnt_q;

   // span per tick for a ramp lasting ds tenths of a second; zero time jumps at once
   function automatic logic [15:0] ramp_step(input logic [15:0] span, input logic [11:0] ds);
      int q;
      q = 0;
      if (ds == 12'h000) return span;
      q = int'(span) / (int'(ds) * plrt_pkg::DS_TICKS);
      return (q == 0) ? 16'h0001 : 16'(q);
   endfunction

   function automatic logic [17:0] ds_ticks(input logic [11:0] ds);
      return 18'(int'(ds) * plrt_pkg::DS_TICKS);
   endfunction

   function automatic logic [15:0] sat_sub(input logic [15:0] a, input logic [15:0] b);
      return (a > b) ? a - b : 16'h0000;
   endfunction

   // default target follows the input voltage setting
   function automatic logic [8:0] tgt_default(input logic [8:0] v);
      return 9'((int'(v) * 122) / 100);
   endfunction

   // thresholds are doubled for the higher voltage class
   logic [9:0] uv_eff, tgt_eff;
   assign uv_eff = ctrl_q.high_class ? {1'b0, lvl_q.uv_level, 1'b0} : {2'b00, lvl_q.uv_level};
   assign tgt_eff = ctrl_q.high_class ? {lvl_q.bus_tgt, 1'b0} : {1'b0, lvl_q.bus_tgt};
   logic uv;
   assign uv = i_bus_v < uv_eff;

   // function code decides mode and contact polarity
   logic fn_fix, fn_reg, bk_en, bk_act;
   assign fn_fix = (ctrl_q.func_sel == plrt_pkg::FN_FIX_NC) || (ctrl_q.func_sel == plrt_pkg::FN_FIX_NO);
   assign fn_reg = (ctrl_q.func_sel == plrt_pkg::FN_REG_NC) || (ctrl_q.func_sel == plrt_pkg::FN_REG_NO);
   assign bk_en = (ctrl_q.mode == 2'h1 || ctrl_q.mode == 2'h2) && (fn_fix || fn_reg);
   // normally-open codes read the terminal active high, normally-closed ones active low
   assign bk_act = (fn_fix || fn_reg) && (i_backup_pin ^ ctrl_q.func_sel[0] ^ fn_reg);

   // backup end: input released, or never came after bus detection
   logic bk_end;
   assign bk_end = (seen_q && !bk_act)
      || (by_volt_q && !seen_q && !bk_act && tmr_q >= 18'(plrt_pkg::VDET_TICKS));

   // fixed mode decel step; fast stop time is specified from full frequency
   logic [15:0] dstep, slip_step, reg_step, nacc_step;
   assign dstep = (dec_q.bk_dec != 12'h000) ? ramp_step(onset_f_q, dec_q.bk_dec)
      : ramp_step(P_FMAX, dec_q.fast_stop);
   assign slip_step = 16'((int'(i_slip) * int'(gain_q.step_gain) * 2) / 100);
   assign nacc_step = ramp_step(P_FMAX, gain_q.norm_acc);
   // rotational energy estimate scales the bus error into a decel rate
   always_comb begin
      int err;
      err = 0;
      if (tgt_eff > i_bus_v) err = int'(tgt_eff) - int'(i_bus_v);
      reg_step = 16'((err * int'(reg2_q.bus_gain) * int'(reg2_q.rate_gain))
         / (int'(reg2_q.accel_ref) + int'(reg2_q.inertia) + 1));
   end

   // control tick divider
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt_q <= 32'h0000_0000;
         tick_q <= 1'b0;
      end else begin
         tick_q <= (cnt_q == 32'(P_TICK_CYC - 1));
         cnt_q <= (cnt_q == 32'(P_TICK_CYC - 1)) ? 32'h0000_0000 : cnt_q + 32'h0000_0001;
      end
   end

   // apb slave, zero wait states
   logic wr, mapped;
   assign wr = i_psel && i_penable && o_pready && i_pwrite;
   assign mapped = (i_paddr <= plrt_pkg::OFS_STAT) && (i_paddr[1:0] == 2'b00);
   plrt_pkg::plrt_stat_t stat;
   always_comb begin
      stat = '0;
      stat.fault = o_uv_fault;
      stat.backup = o_backup;
      stat.out_en = o_out_en;
      stat.by_volt = by_volt_q;
      stat.st = st_q;
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= 32'h0000_0000;
      end else begin
         o_pready <= i_psel && !i_penable;
         o_pslverr <= i_psel && !i_penable && !mapped;
         o_prdata <= 32'h0000_0000;
         if (i_psel && !i_penable && !i_pwrite) begin
            unique case (i_paddr)
               plrt_pkg::OFS_CTRL: o_prdata <= {1'b0, ctrl_q[30:0]};
               plrt_pkg::OFS_TIME: o_prdata <= time_q;
               plrt_pkg::OFS_RAMP: o_prdata <= ramp_q;
               plrt_pkg::OFS_DECEL: o_prdata <= dec_q;
               plrt_pkg::OFS_LEVEL: o_prdata <= lvl_q;
               plrt_pkg::OFS_GAIN: o_prdata <= gain_q;
               plrt_pkg::OFS_INV: o_prdata <= {23'h0, inv_q};
               plrt_pkg::OFS_REG2: o_prdata <= reg2_q;
               plrt_pkg::OFS_STAT: o_prdata <= stat;
               default: o_prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // settings registers; reserved bits are dropped on write
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ctrl_q <= '0;
         time_q <= '{rsv: 8'h00, min_off: plrt_pkg::RST_MINOFF, rsv2: 8'h00, ride: plrt_pkg::RST_RIDE};
         ramp_q <= '{rsv: 8'h00, bk_acc: 8'h00, rsv2: 8'h00, v_ramp: plrt_pkg::RST_VRAMP};
         dec_q <= '{rsv: 4'h0, fast_stop: plrt_pkg::RST_FSTOP, rsv2: 4'h0, bk_dec: 12'h000};
         lvl_q <= '{rsv: 7'h00, bus_tgt: plrt_pkg::RST_TGT, rsv2: 8'h00, uv_level: plrt_pkg::RST_UV};
         gain_q <= '{rsv: 4'h0, norm_acc: plrt_pkg::RST_NACC, rsv2: 7'h00, step_gain: plrt_pkg::RST_GAIN};
         reg2_q <= plrt_pkg::RST_REG2;
         inv_q <= plrt_pkg::RST_INV;
         clr_q <= 1'b0;
      end else begin
         clr_q <= 1'b0;
         if (wr) begin
            unique case (i_paddr)
               plrt_pkg::OFS_CTRL: begin
                  ctrl_q <= i_pwdata;
                  ctrl_q.rsv <= '0;
                  ctrl_q.rsv2 <= '0;
                  ctrl_q.clr_fault <= 1'b0;
                  clr_q <= i_pwdata[31];
               end
               plrt_pkg::OFS_TIME: time_q <= i_pwdata & 32'h00ff_00ff;
               plrt_pkg::OFS_RAMP: ramp_q <= i_pwdata & 32'h00ff_00ff;
               plrt_pkg::OFS_DECEL: dec_q <= i_pwdata & 32'h0fff_0fff;
               plrt_pkg::OFS_LEVEL: lvl_q <= i_pwdata & 32'h01ff_00ff;
               plrt_pkg::OFS_GAIN: gain_q <= i_pwdata & 32'h0fff_01ff;
               plrt_pkg::OFS_REG2: reg2_q <= i_pwdata;
               plrt_pkg::OFS_INV: begin
                  inv_q <= i_pwdata[8:0];
                  lvl_q.uv_level <= plrt_pkg::RST_UV;
                  lvl_q.bus_tgt <= tgt_default(i_pwdata[8:0]);
               end
               default: ;
            endcase
         end
      end
   end

   // sequencer, advanced once per tick
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_q <= plrt_pkg::ST_RUN;
         tmr_q <= 18'h00000;
         onset_f_q <= 16'h0000;
         astep_q <= 16'h0001;
         by_volt_q <= 1'b0;
         seen_q <= 1'b0;
         o_out_en <= 1'b0;
         o_freq <= 16'h0000;
         o_volt <= 10'h000;
         o_uv_fault <= 1'b0;
         o_backup <= 1'b0;
      end else if (tick_q) begin
         unique case (st_q)
            plrt_pkg::ST_RUN: begin
               o_out_en <= i_run;
               o_freq <= i_run ? i_freq_ref : 16'h0000;
               o_volt <= i_run ? plrt_pkg::VMAX : 10'h000;
               tmr_q <= 18'h00000;
               if (i_run && bk_en && (uv || bk_act)) begin
                  st_q <= plrt_pkg::ST_BK_DEC;
                  o_backup <= 1'b1;
                  by_volt_q <= !bk_act;
                  seen_q <= bk_act;
                  onset_f_q <= o_freq;
                  o_freq <= fn_fix ? sat_sub(o_freq, slip_step) : o_freq;
               end else if (i_run && uv) begin
                  o_out_en <= 1'b0;
                  if (ctrl_q.mode == 2'h0) begin
                     st_q <= plrt_pkg::ST_FAULT;
                     o_uv_fault <= 1'b1;
                  end else begin
                     st_q <= plrt_pkg::ST_OFF;
                     tmr_q <= 18'h00001;
                  end
               end
            end
            plrt_pkg::ST_OFF: begin
               o_out_en <= 1'b0;
               tmr_q <= tmr_q + 18'h00001;
               if (uv && ctrl_q.mode == 2'h1 && tmr_q > ds_ticks({4'h0, time_q.ride})) begin
                  st_q <= plrt_pkg::ST_FAULT;
                  o_uv_fault <= 1'b1;
               end else if (!uv && tmr_q >= ds_ticks({4'h0, time_q.min_off})) begin
                  st_q <= plrt_pkg::ST_SRCH;
                  o_volt <= 10'h000;
                  o_out_en <= i_run;
               end
            end
            plrt_pkg::ST_SRCH: begin
               // voltage climbs at full-scale-per-ramp-time
               if (int'(o_volt) + int'(ramp_step(16'(plrt_pkg::VMAX), {4'h0, ramp_q.v_ramp})) >= int'(plrt_pkg::VMAX)) begin
                  o_volt <= plrt_pkg::VMAX;
                  st_q <= plrt_pkg::ST_RUN;
               end else begin
                  o_volt <= o_volt + 10'(ramp_step(16'(plrt_pkg::VMAX), {4'h0, ramp_q.v_ramp}));
               end
            end
            plrt_pkg::ST_BK_DEC: begin
               tmr_q <= tmr_q + 18'h00001;
               if (bk_act) seen_q <= 1'b1;
               if (bk_end) begin
                  o_backup <= 1'b0;
                  if (!i_run) begin
                     st_q <= plrt_pkg::ST_RUN;
                     o_out_en <= 1'b0;
                     o_freq <= 16'h0000;
                  end else begin
                     st_q <= plrt_pkg::ST_BK_ACC;
                     astep_q <= (fn_fix && ramp_q.bk_acc != 8'h00)
                        ? ramp_step(sat_sub(i_freq_ref, o_freq), {4'h0, ramp_q.bk_acc})
                        : nacc_step;
                  end
               end else if (fn_fix) begin
                  o_freq <= sat_sub(o_freq, dstep);
               end else begin
                  o_freq <= sat_sub(o_freq, reg_step);
               end
            end
            plrt_pkg::ST_BK_ACC: begin
               if (!i_run || int'(o_freq) + int'(astep_q) >= int'(i_freq_ref)) begin
                  st_q <= plrt_pkg::ST_RUN;
                  o_freq <= i_run ? i_freq_ref : 16'h0000;
               end else begin
                  o_freq <= o_freq + astep_q;
               end
            end
            plrt_pkg::ST_FAULT: begin
               o_out_en <= 1'b0;
               if (clr_q) begin
                  st_q <= plrt_pkg::ST_RUN;
                  o_uv_fault <= 1'b0;
               end
            end
         endcase
      end else if (clr_q && st_q == plrt_pkg::ST_FAULT) begin
         st_q <= plrt_pkg::ST_RUN; // clear pulse may fall between ticks
         o_uv_fault <= 1'b0;
      end
   end

   // checks
   a_off_holds_output: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      st_q == plrt_pkg::ST_OFF |-> !o_out_en) else $error("output on during off time");
   a_off_min_time: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      $rose(st_q == plrt_pkg::ST_SRCH) |-> $past(tmr_q) >= ds_ticks({4'h0, time_q.min_off}))
      else $error("restart before minimum off time");
   a_ramp_rises: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      st_q == plrt_pkg::ST_SRCH && tick_q |=> o_volt >= $past(o_volt)) else $error("recovery voltage fell");
   a_mode0_trip: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      tick_q && st_q == plrt_pkg::ST_RUN && i_run && uv && !bk_en && ctrl_q.mode == 2'h0 |=> o_uv_fault)
      else $error("undervoltage not tripped");
   a_uv_reinit: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      wr && i_paddr == plrt_pkg::OFS_INV |=> lvl_q.uv_level == plrt_pkg::RST_UV) else $error("level not restored");
   a_backup_gated: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      $rose(o_backup) |-> $past(bk_en)) else $error("backup without enable");
   a_vdet_timeout: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      tick_q && st_q == plrt_pkg::ST_BK_DEC && by_volt_q && !seen_q && !bk_act
      && tmr_q >= 18'(plrt_pkg::VDET_TICKS) |=> !o_backup) else $error("backup outlived 50 ms wait");
   a_release_ends: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      tick_q && st_q == plrt_pkg::ST_BK_DEC && seen_q && !bk_act && i_run |=> st_q == plrt_pkg::ST_BK_ACC)
      else $error("backup not ended on release");
   a_no_reaccel: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      tick_q && st_q == plrt_pkg::ST_BK_DEC && bk_end && !i_run |=> !o_out_en && o_freq == 16'h0000)
      else $error("reaccelerated without run");
   a_fault_off: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      o_uv_fault |-> !o_out_en) else $error("output on with fault");
   // onset and ramp rates, looked at one clock after the tick that applies them
   a_backup_starts: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      tick_q && st_q == plrt_pkg::ST_RUN && i_run && bk_en && (uv || bk_act) |=> o_backup)
      else $error("backup not started");
   a_onset_step: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      tick_q && st_q == plrt_pkg::ST_RUN && i_run && bk_en && (uv || bk_act) && fn_fix
      |=> o_freq == sat_sub($past(o_freq), $past(slip_step))) else $error("onset step wrong");
   a_fixed_reaccel: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      tick_q && st_q == plrt_pkg::ST_BK_DEC && bk_end && i_run && ramp_q.bk_acc == 8'h00
      |=> astep_q == $past(nacc_step)) else $error("reaccel step not normal");
   a_fast_stop_used: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      tick_q && st_q == plrt_pkg::ST_BK_DEC && !bk_end && fn_fix && dec_q.bk_dec == 12'h000
      |=> o_freq == sat_sub($past(o_freq), ramp_step(P_FMAX, $past(dec_q.fast_stop))))
      else $error("fast stop rate not used");
   a_tick_single: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      tick_q |=> !tick_q) else $error("tick longer than one cycle");
   c_fixed_backup: cover property (@(posedge i_clk) disable iff (!i_rst_b)
      st_q == plrt_pkg::ST_BK_DEC && fn_fix ##[1:1000] st_q == plrt_pkg::ST_BK_ACC);
   c_reg_backup: cover property (@(posedge i_clk) disable iff (!i_rst_b)
      st_q == plrt_pkg::ST_BK_DEC && fn_reg ##[1:1000] st_q == plrt_pkg::ST_RUN);
   c_restart: cover property (@(posedge i_clk) disable iff (!i_rst_b) $rose(st_q == plrt_pkg::ST_SRCH));
   c_trip: cover property (@(posedge i_clk) disable iff (!i_rst_b) $rose(o_uv_fault));
   c_run_dropped: cover property (@(posedge i_clk) disable iff (!i_rst_b)
      tick_q && st_q == plrt_pkg::ST_BK_DEC && bk_end && !i_run);
endmodule : plrt_top
`default_nettype wire

// ### verif/plrt_far_side.sv
// Purpose: far side model, dc bus sensing and external undervoltage relay
// Assumes: bench steers loss and relay, changes only after rising edges
// Notes: bus sags well under the 200 V class threshold during a loss
`default_nettype none
module plrt_far_side #(
   parameter logic [9:0] P_NOM = 10'h118,  // 280 V healthy bus
   parameter logic [9:0] P_SAG = 10'h078   // 120 V during a loss
) (
   input wire logic i_clk,           // bench clock
   input wire logic i_rst_b,         // async reset, active low
   input wire logic i_loss,          // supply lost
   input wire logic i_relay,         // relay contact closed
   input wire logic i_act_high,      // terminal polarity
   output logic [9:0] o_bus_v,       // bus voltage, volts
   output logic o_backup_pin         // backup terminal level
);
   // relay is steered by the bench apart from the loss; the pin follows the relay, inverted when i_act_high is low
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_bus_v <= P_NOM;
         o_backup_pin <= !i_act_high;
      end else begin
         o_bus_v <= i_loss ? P_SAG : P_NOM;
         o_backup_pin <= i_relay ~^ i_act_high;
      end
   end
endmodule // plrt_far_side
`default_nettype wire

// ### verif/plrt_top_test.sv
// Purpose: self-checking bench of the ride-through sequencer
// Assumes: control tick shortened to 20 clocks, times scale in ticks
// Notes: waits follow the tick counts that the settings fix
`default_nettype none
module plrt_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TK = 20;
   logic i_clk, i_rst_b, psel, penable, pwrite, loss, relay, act_hi, run, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [9:0] bus_v, volt;
   logic bk_pin, out_en, uv_fault, backup;
   logic [15:0] freq;
   int bad_count, total_checks, cyc = 0;
   plrt_top #(.P_TICK_CYC(TK)) DUT (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_bus_v(bus_v), .i_backup_pin(bk_pin), .i_run(run), .i_freq_ref(16'h0bb8),
      .i_slip(16'h0032), .o_out_en(out_en), .o_freq(freq), .o_volt(volt), .o_uv_fault(uv_fault), .o_backup(backup));
   plrt_far_side FAR (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_loss(loss), .i_relay(relay), .i_act_high(act_hi),
      .o_bus_v(bus_v), .o_backup_pin(bk_pin));
   initial begin
      i_clk = 1'h0;
      forever #10 i_clk = ~i_clk;
   end
   task automatic final_report;
      if (bad_count == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", nm, exp, got);
         bad_count++;
      end
   endtask
   // one apb transfer, held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge i_clk);
      penable <= 1'h1;
      do begin
         @(posedge i_clk);
      end while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0; penable <= 1'h0;
   endtask
   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
      apb(1'h0, a, 32'h0);
      chk(nm, exp, rd);
   endtask
   task automatic tk(input int n);
      repeat (n * TK) @(posedge i_clk);
   endtask
   function automatic logic [31:0] ctl(input logic c, input logic h, input logic [7:0] f, input logic [1:0] m);
      return {c, 14'h0, h, f, 6'h0, m};
   endfunction
   // a hang is cut short and reported as a mismatch
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 60000) begin
         bad_count++;
         final_report;
      end
   end
   initial begin
      i_rst_b = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = 8'h00; pwdata = 32'h0;
      loss = 1'h0; relay = 1'h0; act_hi = 1'h1; run = 1'h1; bad_count = 0; total_checks = 0;
      repeat (4) @(posedge i_clk);
      i_rst_b <= 1'h1;
      rdc("level", plrt_pkg::OFS_LEVEL, 32'h00f4_00be);
      rdc("times", plrt_pkg::OFS_TIME, 32'h0005_0005);
      rdc("unmapped", 8'h24, 32'h0);
      chk("slverr", 32'h1, {31'h0, err});
      // lowered level must snap back when the input voltage is written
      apb(1'h1, plrt_pkg::OFS_LEVEL, 32'h0100_0096);
      apb(1'h1, plrt_pkg::OFS_INV, 32'h0000_00c8);
      rdc("level", plrt_pkg::OFS_LEVEL, 32'h00f4_00be);
      // short loss: output off 100 ticks from onset, then 300 tick ramp
      apb(1'h1, plrt_pkg::OFS_CTRL, ctl(1'h0, 1'h0, 8'h00, 2'h1));
      apb(1'h1, plrt_pkg::OFS_TIME, 32'h0001_0005);
      tk(5);
      loss <= 1'h1;
      tk(10);
      loss <= 1'h0;
      tk(80);
      chk("out_en", 32'h0, {31'h0, out_en});
      tk(380);
      chk("out_en", 32'h1, {31'h0, out_en});
      chk("volt", {22'h0, plrt_pkg::VMAX}, {22'h0, volt});
      // long loss trips after the 500 tick ride-through time
      loss <= 1'h1;
      tk(480);
      chk("fault", 32'h0, {31'h0, uv_fault});
      tk(40);
      chk("fault", 32'h1, {31'h0, uv_fault});
      chk("out_en", 32'h0, {31'h0, out_en});
      loss <= 1'h0;
      apb(1'h1, plrt_pkg::OFS_CTRL, ctl(1'h1, 1'h0, 8'h00, 2'h1));
      tk(2);
      chk("fault", 32'h0, {31'h0, uv_fault});
      tk(450);
      // short normal accel keeps every reacceleration within a few ticks
      apb(1'h1, plrt_pkg::OFS_GAIN, 32'h0001_0064);
      // bus detection with no terminal: backup gives up after 50 ticks
      apb(1'h1, plrt_pkg::OFS_CTRL, ctl(1'h0, 1'h0, plrt_pkg::FN_FIX_NO, 2'h2));
      tk(3);
      loss <= 1'h1;
      tk(3);
      loss <= 1'h0;
      chk("backup", 32'h1, {31'h0, backup});
      tk(60);
      chk("backup", 32'h0, {31'h0, backup});
      tk(20);
      chk("freq", 32'h0000_0bb8, {16'h0, freq});
      relay <= 1'h1;
      tk(3);
      chk("backup", 32'h1, {31'h0, backup});
      tk(60);
      chk("backup", 32'h1, {31'h0, backup});
      relay <= 1'h0;
      tk(3);
      chk("backup", 32'h0, {31'h0, backup});
      tk(20);
      chk("freq", 32'h0000_0bb8, {16'h0, freq});
      // regulating mode: sagging bus slows the motor, release reaccelerates
      apb(1'h1, plrt_pkg::OFS_CTRL, ctl(1'h0, 1'h0, plrt_pkg::FN_REG_NO, 2'h2));
      loss <= 1'h1;
      relay <= 1'h1;
      tk(3);
      chk("backup", 32'h1, {31'h0, backup});
      chk("slowing", 32'h1, {31'h0, freq < 16'h0bb8});
      loss <= 1'h0;
      relay <= 1'h0;
      tk(50);
      chk("freq", 32'h0000_0bb8, {16'h0, freq});
      // run dropped during backup: no reacceleration
      relay <= 1'h1;
      tk(3);
      run <= 1'h0;
      relay <= 1'h0;
      tk(3);
      chk("out_en", 32'h0, {31'h0, out_en});
      chk("freq", 32'h0, {16'h0, freq});
      run <= 1'h1;
      // mode 0 keeps backup off even with a code assigned
      apb(1'h1, plrt_pkg::OFS_CTRL, ctl(1'h0, 1'h0, plrt_pkg::FN_FIX_NO, 2'h0));
      relay <= 1'h1;
      tk(3);
      chk("backup", 32'h0, {31'h0, backup});
      relay <= 1'h0;
      // doubled level puts a healthy 280 V bus under threshold
      apb(1'h1, plrt_pkg::OFS_CTRL, ctl(1'h0, 1'h1, 8'h00, 2'h0));
      tk(3);
      chk("fault", 32'h1, {31'h0, uv_fault});
      final_report;
   end
endmodule // plrt_top_test
`default_nettype wire
